// file: hw/tcrd_pkg.sv
// Package for the tuner control register bank: register addresses, field positions,
// reset values, enumerations and the carrier structs shared by the design and bench.
// Assumes an 8-bit parallel control bus with active-low strobes.
package tcrd_pkg;

  // Register addresses on the control bus.
  localparam logic [7:0] TCRD_ADDR_DEC_LO = 8'h00;
  localparam logic [7:0] TCRD_ADDR_DEC_HI = 8'h01;
  localparam logic [7:0] TCRD_ADDR_SHIFT = 8'h02;
  localparam logic [7:0] TCRD_ADDR_GAIN_A = 8'h03;
  localparam logic [7:0] TCRD_ADDR_GAIN_B = 8'h04;
  localparam logic [7:0] TCRD_ADDR_RATE = 8'h05;
  localparam logic [7:0] TCRD_ADDR_SOUT = 8'h06;
  localparam logic [7:0] TCRD_ADDR_TEST = 8'h07;
  localparam logic [7:0] TCRD_ADDR_XBAR = 8'h08;
  localparam logic [7:0] TCRD_ADDR_AGC = 8'h09;
  localparam logic [7:0] TCRD_ADDR_GIC_A = 8'h0a;
  localparam logic [7:0] TCRD_ADDR_GIC_B = 8'h0b;
  localparam logic [7:0] TCRD_ADDR_DEBUG = 8'h0c;

  // Field positions inside the decimation high byte, the serial output byte and the debug register.
  localparam int TCRD_BIT_QUAD = 4;
  localparam int TCRD_BIT_SERIAL_PINS_ENABLE = 0;
  localparam int TCRD_BIT_EDGE = 1;
  localparam int TCRD_BIT_FRAME_SYNC_POLARITY = 2;
  localparam int TCRD_BIT_SAMPLE_READY_POLARITY = 3;
  localparam int TCRD_BIT_MERGE = 4;
  localparam int TCRD_BIT_PACK = 5;
  localparam int TCRD_BIT_FMT = 6;
  localparam int TCRD_BIT_DBG_EN = 7;

  // Reset values and limits.
  localparam logic [10:0] TCRD_DEC_RESET = 11'h007;
  localparam logic [10:0] TCRD_DEC_MIN = 11'h007;
  localparam logic [5:0] TCRD_SHIFT_MAX = 6'h28;
  localparam logic [7:0] TCRD_RATE_RESET = 8'h01;
  localparam logic [7:0] TCRD_ZERO8 = 8'h00;

  // Strobe divider limits for each debug tap; the strobe comes every limit plus one input clocks.
  localparam logic [7:0] TCRD_DBG_DIV_NCO = 8'h00;
  localparam logic [7:0] TCRD_DBG_DIV_MIX = 8'h00;
  localparam logic [7:0] TCRD_DBG_DIV_FIR1 = 8'h03;
  localparam logic [7:0] TCRD_DBG_DIV_FIR2 = 8'h07;
  localparam logic [7:0] TCRD_DBG_DIV_CIC = 8'h07;

  // Output number encodings.
  typedef enum logic [1:0] {
    TCRD_FMT_TRUNC8,
    TCRD_FMT_ROUND16,
    TCRD_FMT_ROUND24,
    TCRD_FMT_FLOAT
  } tcrd_fmt_t;

  // Debug tap points.
  typedef enum logic [2:0] {
    TCRD_TAP_NCO,
    TCRD_TAP_MIXER,
    TCRD_TAP_FIR1_IN,
    TCRD_TAP_FIR2_IN,
    TCRD_TAP_AGC_CIC
  } tcrd_tap_t;

  // Host control bus request.
  typedef struct packed {
    logic ce_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcrd_bus_t;

  // Configuration handed to the datapath.
  typedef struct packed {
    logic [10:0] cic_decimation_word;
    logic second_fir_quad_decimate;
    logic [5:0] cic_input_shift;
    logic [2:0] chan_a_fir_shift;
    logic [2:0] chan_b_fir_shift;
    logic [7:0] serial_clock_divider;
    logic serial_pins_enable;
    logic serial_clock_edge_select;
    logic frame_sync_polarity;
    logic sample_ready_polarity;
    logic serial_channel_merge;
    logic iq_pair_framing;
    tcrd_fmt_t output_number_encoding;
    logic effective_pack;
    logic [1:0] chan_a_input_select;
    logic [1:0] chan_b_input_select;
    logic [13:0] test_sample;
    logic gain_loop_open_control;
    logic [7:0] gain_initial_value_a;
    logic [7:0] gain_initial_value_b;
  } tcrd_cfg_t;

  // Normal-mode output pin values from the serial and parallel output logic.
  typedef struct packed {
    logic [15:0] parallel_sample_pins;
    logic sample_ready;
    logic serial_frame_sync;
    logic chan_a_serial_data;
    logic chan_b_serial_data;
    logic serial_clock;
  } tcrd_pins_t;

  // Debug tap values from the datapath.
  typedef struct packed {
    logic [19:0] nco;
    logic [19:0] mixer;
    logic [19:0] fir1_in;
    logic [19:0] fir2_in;
    logic [19:0] agc_cic;
  } tcrd_taps_t;

endpackage

// file: hw/tcrd_regs.sv
// Control register bank and debug multiplexer of the dual-channel downconverter.
// Assumes the host drives the control bus from outside the clock domain, and that the
// datapath supplies normal-mode pin values and debug taps on clk_sys.
//
// Contract
// RQ1 - 8-bit registers over parallel strobed bus.
// RQ2 - Eleven-bit decimation word split over two addresses.
// RQ3 - Address 1 bit 4 selects decimate-by-four.
// RQ4 - Six-bit CIC input shift, zero to forty.
// RQ5 - Per-channel three-bit FIR input shifts.
// RQ6 - Serial clock equals input clock over divider plus one.
// RQ7 - Serial pins tri-stated unless enabled.
// RQ8 - Edge select chooses serial change edge.
// RQ9 - Frame sync and ready polarity bits.
// RQ10 - Merge both channels onto channel A pin.
// RQ11 - Frame sync per word or per pair.
// RQ12 - Two-bit output number format field.
// RQ13 - Test register substitutes channel inputs.
// RQ14 - Gain-hold forces gain from initial value.
// RQ15 - Debug register selects one tap point.
// RQ16 - Tap drives twenty-bit bus onto pins.
// RQ17 - Debug serial clock at tap strobe rate.
// RQ18 - Debug mode overrides normal outputs and enables.
// RQ19 - Host holds sync before stopping clock.
// RQ20 - Host keeps sample period five clocks.
// RQ21 - Floating point always sent packed.
// RQ22 - Reads return stored values, no side effects.
`timescale 1ns/1ps

module tcrd_regs
  import tcrd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic parallel_output_enable_n,
  input wire logic [2:0] parallel_segment_select,
  input wire tcrd_pins_t normal_pins,
  input wire tcrd_taps_t debug_taps,
  output tcrd_cfg_t cfg,
  output logic [2:0] segment_select,
  output logic [15:0] parallel_sample_pins,
  output logic parallel_pins_oe,
  output logic sample_ready,
  output logic serial_frame_sync,
  output logic chan_a_serial_data,
  output logic chan_b_serial_data,
  output logic serial_clock,
  output logic serial_pins_oe,
  output logic serial_rate_tick
);

  // Three-stage synchronisers for the host strobes and address/data.
  logic [2:0] ce_sync_reg, rd_sync_reg, wr_sync_reg;
  logic [7:0] addr_s1_reg, addr_s2_reg, addr_s3_reg;
  logic [7:0] din_s1_reg, din_s2_reg, din_s3_reg;
  logic wr_seen_reg;
  logic ce_q, rd_q, wr_q, wr_pulse;

  // Register storage.
  logic [7:0] dec_lo_reg, dec_hi_reg, shift_reg, gain_a_reg, gain_b_reg, rate_reg;
  logic [7:0] sout_reg, test_lo_reg, xbar_reg, agc_reg, gic_a_reg, gic_b_reg, debug_reg;
  logic [7:0] rd_next;
  logic [7:0] div_cnt_reg, div_limit;
  logic sck_reg;
  logic debug_mode;
  logic [19:0] tap_bus;

  // Returns the divider limit that matches a debug tap.
  function automatic logic [7:0] tap_div(input logic [2:0] tap);
    case (tap)
      TCRD_TAP_NCO: tap_div = TCRD_DBG_DIV_NCO;
      TCRD_TAP_MIXER: tap_div = TCRD_DBG_DIV_MIX;
      TCRD_TAP_FIR1_IN: tap_div = TCRD_DBG_DIV_FIR1;
      TCRD_TAP_FIR2_IN: tap_div = TCRD_DBG_DIV_FIR2;
      default: tap_div = TCRD_DBG_DIV_CIC;
    endcase
  endfunction

  // Strobes are stable once the second and third stages agree.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ce_sync_reg <= 3'h7;
      rd_sync_reg <= 3'h7;
      wr_sync_reg <= 3'h7;
      addr_s1_reg <= 8'h00;
      addr_s2_reg <= 8'h00;
      addr_s3_reg <= 8'h00;
      din_s1_reg <= 8'h00;
      din_s2_reg <= 8'h00;
      din_s3_reg <= 8'h00;
    end else begin
      ce_sync_reg <= {ce_sync_reg[1:0], ce_n};
      rd_sync_reg <= {rd_sync_reg[1:0], rd_n};
      wr_sync_reg <= {wr_sync_reg[1:0], wr_n};
      addr_s1_reg <= addr;
      addr_s2_reg <= addr_s1_reg;
      addr_s3_reg <= addr_s2_reg;
      din_s1_reg <= data_in;
      din_s2_reg <= din_s1_reg;
      din_s3_reg <= din_s2_reg;
    end
  end

  // Active strobe levels taken only when the last two stages agree.
  assign ce_q = ~ce_sync_reg[1] & ~ce_sync_reg[2];
  assign rd_q = ~rd_sync_reg[1] & ~rd_sync_reg[2] & ce_q;
  assign wr_q = ~wr_sync_reg[1] & ~wr_sync_reg[2] & ce_q;
  assign wr_pulse = wr_q & ~wr_seen_reg;

  // One write per strobe assertion.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_seen_reg <= 1'b0;
    end else begin
      wr_seen_reg <= wr_q;
    end
  end

  // Register writes; each address stores one 8-bit byte.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dec_lo_reg <= TCRD_DEC_RESET[7:0];
      dec_hi_reg <= TCRD_ZERO8;
      shift_reg <= TCRD_ZERO8;
      gain_a_reg <= TCRD_ZERO8;
      gain_b_reg <= TCRD_ZERO8;
      rate_reg <= TCRD_RATE_RESET; // [RQ6]
      sout_reg <= TCRD_ZERO8;
      test_lo_reg <= TCRD_ZERO8;
      xbar_reg <= TCRD_ZERO8;
      agc_reg <= TCRD_ZERO8;
      gic_a_reg <= TCRD_ZERO8;
      gic_b_reg <= TCRD_ZERO8;
      debug_reg <= TCRD_ZERO8;
    end else if (wr_pulse) begin // [RQ1]
      case (addr_s3_reg)
        TCRD_ADDR_DEC_LO: dec_lo_reg <= din_s3_reg; // [RQ2]
        TCRD_ADDR_DEC_HI: dec_hi_reg <= din_s3_reg & 8'h17; // [RQ2] [RQ3]
        TCRD_ADDR_SHIFT: shift_reg <= din_s3_reg & 8'h3f; // [RQ4]
        TCRD_ADDR_GAIN_A: gain_a_reg <= din_s3_reg & 8'h07; // [RQ5]
        TCRD_ADDR_GAIN_B: gain_b_reg <= din_s3_reg & 8'h07; // [RQ5]
        TCRD_ADDR_RATE: rate_reg <= din_s3_reg;
        TCRD_ADDR_SOUT: sout_reg <= din_s3_reg; // [RQ12]
        TCRD_ADDR_TEST: test_lo_reg <= din_s3_reg; // [RQ13]
        TCRD_ADDR_XBAR: xbar_reg <= din_s3_reg & 8'h3f;
        TCRD_ADDR_AGC: agc_reg <= din_s3_reg & 8'h01; // [RQ14]
        TCRD_ADDR_GIC_A: gic_a_reg <= din_s3_reg;
        TCRD_ADDR_GIC_B: gic_b_reg <= din_s3_reg;
        TCRD_ADDR_DEBUG: debug_reg <= din_s3_reg & 8'h87; // [RQ15]
        default: ;
      endcase
    end
  end

  // Read mux; unused bits are zero already because writes mask them.
  always_comb begin
    case (addr_s3_reg)
      TCRD_ADDR_DEC_LO: rd_next = dec_lo_reg; // [RQ22]
      TCRD_ADDR_DEC_HI: rd_next = dec_hi_reg;
      TCRD_ADDR_SHIFT: rd_next = shift_reg;
      TCRD_ADDR_GAIN_A: rd_next = gain_a_reg;
      TCRD_ADDR_GAIN_B: rd_next = gain_b_reg;
      TCRD_ADDR_RATE: rd_next = rate_reg;
      TCRD_ADDR_SOUT: rd_next = sout_reg;
      TCRD_ADDR_TEST: rd_next = test_lo_reg;
      TCRD_ADDR_XBAR: rd_next = xbar_reg;
      TCRD_ADDR_AGC: rd_next = agc_reg;
      TCRD_ADDR_GIC_A: rd_next = gic_a_reg;
      TCRD_ADDR_GIC_B: rd_next = gic_b_reg;
      TCRD_ADDR_DEBUG: rd_next = debug_reg;
      default: rd_next = TCRD_ZERO8;
    endcase
  end

  // Read data is registered, and data_oe is the synchronised read strobe (rd_q) delayed by one clock.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_out <= rd_next; // [RQ22]
      data_oe <= rd_q; // [RQ1]
    end
  end

  // Configuration outputs to the datapath.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg <= '0;
      cfg.cic_decimation_word <= TCRD_DEC_RESET;
      cfg.serial_clock_divider <= TCRD_RATE_RESET;
    end else begin
      cfg.cic_decimation_word <= {dec_hi_reg[2:0], dec_lo_reg}; // [RQ2]
      cfg.second_fir_quad_decimate <= dec_hi_reg[TCRD_BIT_QUAD]; // [RQ3]
      cfg.cic_input_shift <= (shift_reg[5:0] > TCRD_SHIFT_MAX) ? TCRD_SHIFT_MAX
                             : shift_reg[5:0]; // [RQ4]
      cfg.chan_a_fir_shift <= gain_a_reg[2:0]; // [RQ5]
      cfg.chan_b_fir_shift <= gain_b_reg[2:0]; // [RQ5]
      cfg.serial_clock_divider <= rate_reg;
      cfg.serial_pins_enable <= sout_reg[TCRD_BIT_SERIAL_PINS_ENABLE];
      cfg.serial_clock_edge_select <= sout_reg[TCRD_BIT_EDGE]; // [RQ8]
      cfg.frame_sync_polarity <= sout_reg[TCRD_BIT_FRAME_SYNC_POLARITY]; // [RQ9]
      cfg.sample_ready_polarity <= sout_reg[TCRD_BIT_SAMPLE_READY_POLARITY]; // [RQ9]
      cfg.serial_channel_merge <= sout_reg[TCRD_BIT_MERGE]; // [RQ10]
      cfg.iq_pair_framing <= sout_reg[TCRD_BIT_PACK]; // [RQ11]
      cfg.output_number_encoding <= tcrd_fmt_t'(sout_reg[TCRD_BIT_FMT +: 2]); // [RQ12]
      cfg.effective_pack <= sout_reg[TCRD_BIT_PACK] |
                            (sout_reg[TCRD_BIT_FMT +: 2] == TCRD_FMT_FLOAT); // [RQ21]
      cfg.chan_a_input_select <= xbar_reg[1:0]; // [RQ13]
      cfg.chan_b_input_select <= xbar_reg[3:2]; // [RQ13]
      cfg.test_sample <= {xbar_reg[5:0], test_lo_reg}; // [RQ13]
      cfg.gain_loop_open_control <= agc_reg[0]; // [RQ14]
      cfg.gain_initial_value_a <= gic_a_reg; // [RQ14]
      cfg.gain_initial_value_b <= gic_b_reg; // [RQ14]
    end
  end

  assign debug_mode = debug_reg[TCRD_BIT_DBG_EN];
  assign div_limit = debug_mode ? tap_div(debug_reg[2:0]) : rate_reg; // [RQ17]

  // Tap selection for the debug bus.
  always_comb begin
    case (debug_reg[2:0])
      TCRD_TAP_NCO: tap_bus = debug_taps.nco; // [RQ15]
      TCRD_TAP_MIXER: tap_bus = debug_taps.mixer;
      TCRD_TAP_FIR1_IN: tap_bus = debug_taps.fir1_in;
      TCRD_TAP_FIR2_IN: tap_bus = debug_taps.fir2_in;
      default: tap_bus = debug_taps.agc_cic;
    endcase
  end

  // Serial clock divider: a rate tick every divider+1 input clocks.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt_reg <= 8'h00;
      serial_rate_tick <= 1'b0;
      sck_reg <= 1'b0;
    end else if (div_cnt_reg >= div_limit) begin
      div_cnt_reg <= 8'h00;
      serial_rate_tick <= 1'b1; // [RQ6]
      sck_reg <= ~sck_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
      serial_rate_tick <= 1'b0;
    end
  end

  // Pin drivers: debug mode overrides normal data and the enables.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      parallel_sample_pins <= 16'h0000;
      parallel_pins_oe <= 1'b0;
      sample_ready <= 1'b0;
      serial_frame_sync <= 1'b0;
      chan_a_serial_data <= 1'b0;
      chan_b_serial_data <= 1'b0;
      serial_clock <= 1'b0;
      serial_pins_oe <= 1'b0;
      segment_select <= 3'h0;
    end else if (debug_mode) begin
      parallel_sample_pins <= tap_bus[19:4]; // [RQ16]
      sample_ready <= tap_bus[3]; // [RQ16]
      serial_frame_sync <= tap_bus[2];
      chan_a_serial_data <= tap_bus[1];
      chan_b_serial_data <= tap_bus[0];
      serial_clock <= sck_reg; // [RQ17]
      parallel_pins_oe <= 1'b1; // [RQ18]
      serial_pins_oe <= 1'b1; // [RQ18]
      segment_select <= 3'h0; // [RQ18]
    end else begin
      parallel_sample_pins <= normal_pins.parallel_sample_pins;
      sample_ready <= normal_pins.sample_ready ^ sout_reg[TCRD_BIT_SAMPLE_READY_POLARITY]; // [RQ9]
      serial_frame_sync <= normal_pins.serial_frame_sync ^
                           sout_reg[TCRD_BIT_FRAME_SYNC_POLARITY]; // [RQ9]
      chan_a_serial_data <= normal_pins.chan_a_serial_data;
      chan_b_serial_data <= normal_pins.chan_b_serial_data;
      serial_clock <= normal_pins.serial_clock ^ sout_reg[TCRD_BIT_EDGE]; // [RQ8]
      parallel_pins_oe <= ~parallel_output_enable_n;
      serial_pins_oe <= sout_reg[TCRD_BIT_SERIAL_PINS_ENABLE]; // [RQ7]
      segment_select <= parallel_segment_select;
    end
  end

endmodule

// file: bench/tcrd_regs_asserts.sv
// Port checks for the tuner control register bank, bound into every instance.
// Assumes one clk_sys domain with synchronous active-high rst.
`timescale 1ns/1ps

module tcrd_regs_asserts
  import tcrd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic data_oe,
  input wire tcrd_pins_t normal_pins,
  input wire tcrd_cfg_t cfg,
  input wire logic [2:0] segment_select,
  input wire logic sample_ready,
  input wire logic serial_pins_oe,
  input wire logic serial_rate_tick
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic [8:0] gap;
  logic gap_ok;

  // Clocks since the last tick; a period is judged only when no write can move the divider.
  always_ff @(posedge clk_sys) gap <= (rst || serial_rate_tick) ? 9'h000 : gap + 9'h001;
  always_ff @(posedge clk_sys) gap_ok <= (rst || !wr_n) ? 1'b0 : (gap_ok || serial_rate_tick);

  property p_read_answer;
    $rose(data_oe) |-> $past(!rd_n && !ce_n, 3);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("data driven without a read");
  property p_reset_vals;
    $fell(rst) |-> cfg.cic_decimation_word == 11'h007 && cfg.serial_clock_divider == 8'h01;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset config");
  property p_shift_clamp;
    cfg.cic_input_shift <= 6'h28;
  endproperty
  a_shift_clamp: assert property (p_shift_clamp) else $error("shift above forty");
  property p_pack;
    cfg.effective_pack == (cfg.iq_pair_framing || cfg.output_number_encoding == TCRD_FMT_FLOAT);
  endproperty
  a_pack: assert property (p_pack) else $error("packing wrong");
  property p_cfg_quiet;
    wr_n [*6] |=> $stable(cfg);
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet) else $error("config moved without write");
  property p_ser_oe;
    cfg.serial_pins_enable |-> serial_pins_oe;
  endproperty
  a_ser_oe: assert property (p_ser_oe) else $error("serial pins not driven");
  property p_tick;
    serial_rate_tick && gap_ok && segment_select != 3'h0 |->
      gap == {1'b0, cfg.serial_clock_divider};
  endproperty
  a_tick: assert property (p_tick) else $error("rate tick period wrong");
  property p_sample_ready_polarity;
    segment_select != 3'h0 |->
      sample_ready == ($past(normal_pins.sample_ready) ^ cfg.sample_ready_polarity);
  endproperty
  a_sample_ready_polarity: assert property (p_sample_ready_polarity) else $error("ready polarity wrong");

  // Main scenarios reached.
  c_read: cover property (data_oe);
  c_tick: cover property (serial_rate_tick && gap_ok);
  c_float: cover property (cfg.output_number_encoding == TCRD_FMT_FLOAT);
endmodule

bind tcrd_regs tcrd_regs_asserts u_asserts (.clk_sys, .rst, .ce_n, .rd_n, .wr_n, .data_oe,
  .normal_pins, .cfg, .segment_select, .sample_ready, .serial_pins_oe, .serial_rate_tick);

// file: bench/tcrd_host.sv
// Host processor model on the parallel control bus.
// Assumes the bench resolves the shared data wires from both drive enables.
`timescale 1ns/1ps

module tcrd_host (
  input wire logic clk_sys,
  input wire logic data_oe,
  input wire logic [7:0] data_out,
  output logic ce_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] addr,
  output logic [7:0] host_data,
  output logic host_oe
);
  // The input clock never stops here, so the stop-clock sync hold never arises.
  // Parallel output is not sampled, so any divider value is a legal host write.
  // Bus idles with strobes high and data released.
  initial begin
    {ce_n, rd_n, wr_n, host_oe} = 4'he;
    addr = 8'h00;
    host_data = 8'h00;
  end

  // Address and data lead the strobe by a clock and hold until it rises.
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 {addr, host_data, host_oe} = {a, d, 1'b1};
    @(posedge clk_sys);
    #1 {ce_n, wr_n} = 2'b00;
    repeat (6) @(posedge clk_sys);
    #1 {ce_n, wr_n, host_oe} = 3'b110;
    repeat (3) @(posedge clk_sys);
  endtask

  // Read strobe holds until the drive enable is seen; data is taken at that edge.
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk_sys);
    #1 addr = a;
    repeat (4) @(posedge clk_sys);
    #1 {ce_n, rd_n} = 2'b00;
    for (int i = 0; i < 12 && !ok; i++) begin
      @(posedge clk_sys);
      #1 ok = (data_oe === 1'b1);
      d = data_out;
    end
    {ce_n, rd_n} = 2'b11;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule

// file: bench/tuner_control_regs_and_debug_mux_test.sv
// Self-checking bench for the tuner control register bank and debug multiplexer.
// Assumes the host model drives the bus; the bench resolves the shared data wires.
`timescale 1ns/1ps

module tuner_control_regs_and_debug_mux_test;
  import tcrd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce_n, rd_n, wr_n, data_oe, host_oe, parallel_output_enable_n, parallel_pins_oe;
  logic sample_ready, serial_frame_sync, chan_a_serial_data, chan_b_serial_data;
  logic serial_clock, serial_pins_oe, serial_rate_tick;
  logic [7:0] addr, host_data, data_out, data_in;
  logic [2:0] parallel_segment_select, segment_select;
  logic [15:0] parallel_sample_pins;
  tcrd_pins_t normal_pins;
  tcrd_taps_t debug_taps;
  tcrd_cfg_t cfg;
  logic [7:0] shadow [16];
  logic [7:0] mask [16] = '{8'hff, 8'h17, 8'h3f, 8'h07, 8'h07, 8'hff, 8'hff, 8'hff,
    8'h3f, 8'h01, 8'hff, 8'hff, 8'h87, 8'h00, 8'h00, 8'h00};
  logic [15:0] corner [10] = '{16'h0c00, 16'h00ff, 16'h01ff, 16'h023f, 16'h0229,
    16'h0228, 16'hff5a, 16'h0e33, 16'h0507, 16'h0601};
  int fail_count = 0;
  int checks_done = 0;
  int seed = 31;

  always #50 clk_sys = ~clk_sys;
  // Undriven data wires change every half cycle so a stale value cannot pass.
  assign data_in = data_oe ? data_out : (host_oe ? host_data : 8'h5a ^ {8{clk_sys}});

  tcrd_regs dut (.clk_sys, .rst, .ce_n, .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe,
    .parallel_output_enable_n, .parallel_segment_select, .normal_pins, .debug_taps, .cfg,
    .segment_select, .parallel_sample_pins, .parallel_pins_oe, .sample_ready,
    .serial_frame_sync, .chan_a_serial_data, .chan_b_serial_data, .serial_clock,
    .serial_pins_oe, .serial_rate_tick);
  tcrd_host host (.clk_sys, .data_oe, .data_out, .ce_n, .rd_n, .wr_n, .addr, .host_data,
    .host_oe);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input logic [79:0] got, input logic [79:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected configuration from the stored register images.
  function automatic tcrd_cfg_t exp_cfg();
    tcrd_cfg_t c;
    c.cic_decimation_word = {shadow[1][2:0], shadow[0]};
    c.second_fir_quad_decimate = shadow[1][4];
    c.cic_input_shift = (shadow[2][5:0] > 6'h28) ? 6'h28 : shadow[2][5:0];
    c.chan_a_fir_shift = shadow[3][2:0];
    c.chan_b_fir_shift = shadow[4][2:0];
    c.serial_clock_divider = shadow[5];
    {c.iq_pair_framing, c.serial_channel_merge, c.sample_ready_polarity,
      c.frame_sync_polarity, c.serial_clock_edge_select, c.serial_pins_enable} = shadow[6][5:0];
    c.output_number_encoding = tcrd_fmt_t'(shadow[6][7:6]);
    c.effective_pack = shadow[6][5] | (shadow[6][7:6] == 2'h3);
    {c.chan_b_input_select, c.chan_a_input_select} = shadow[8][3:0];
    c.test_sample = {shadow[8][5:0], shadow[7]};
    c.gain_loop_open_control = shadow[9][0];
    c.gain_initial_value_a = shadow[10];
    c.gain_initial_value_b = shadow[11];
    return c;
  endfunction

  task automatic rd_check(input logic [7:0] a);
    logic [7:0] d;
    bit ok;
    host.bus_read(a, d, ok);
    if (!ok) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, ok, 1'b1);
      give_verdict();
    end else begin
      cmp(d, (a < 8'h10) ? shadow[a[3:0]] : 8'h00);
    end
  endtask

  // Fresh pin and tap values, settle, then every output pin against the mode, serial_clock only in normal mode.
  task automatic check_pins();
    logic [127:0] r;
    logic [19:0] tap;
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    @(posedge clk_sys);
    #1 debug_taps = r[99:0];
    {parallel_output_enable_n, parallel_segment_select} = r[103:100];
    normal_pins = tcrd_pins_t'(r[124:104]);
    repeat (3) @(posedge clk_sys);
    #1 case (shadow[12][2:0])
      3'h0: tap = debug_taps.nco;
      3'h1: tap = debug_taps.mixer;
      3'h2: tap = debug_taps.fir1_in;
      3'h3: tap = debug_taps.fir2_in;
      default: tap = debug_taps.agc_cic;
    endcase
    if (shadow[12][7]) begin
      cmp({parallel_sample_pins, sample_ready, serial_frame_sync, chan_a_serial_data,
        chan_b_serial_data, serial_pins_oe, parallel_pins_oe, segment_select}, {tap, 5'h18});
    end else begin
      cmp({parallel_sample_pins, sample_ready, serial_frame_sync, serial_pins_oe,
        parallel_pins_oe, segment_select, chan_a_serial_data, chan_b_serial_data,
        serial_clock}, {normal_pins.parallel_sample_pins,
        normal_pins.sample_ready ^ shadow[6][3], normal_pins.serial_frame_sync ^ shadow[6][2],
        shadow[6][0], ~parallel_output_enable_n, parallel_segment_select,
        normal_pins.chan_a_serial_data, normal_pins.chan_b_serial_data,
        normal_pins.serial_clock ^ shadow[6][1]});
    end
  endtask

  task automatic step(input logic [7:0] a, input logic [7:0] d);
    host.bus_write(a, d);
    if (a < 8'h10) begin
      shadow[a[3:0]] = d & mask[a[3:0]];
    end
    rd_check(a);
    cmp(cfg, exp_cfg());
    check_pins();
  endtask

  initial begin
    logic [31:0] r;
    {parallel_output_enable_n, parallel_segment_select} = 4'h9;
    normal_pins = '0;
    debug_taps = '0;
    foreach (shadow[i]) shadow[i] = 8'h00;
    shadow[0] = 8'h07;
    shadow[5] = 8'h01;
    repeat (8) @(posedge clk_sys);
    #1 rst = 1'b0;
    cmp(cfg, exp_cfg());
    for (int i = 0; i < 16; i++) begin
      rd_check(i[7:0]);
    end
    // Every format code and every tap, with packing toggled against float.
    for (int k = 0; k < 5; k++) begin
      step(8'h06, {k[1:0], ~k[0], 5'h0d});
      step(8'h0c, {5'h10, k[2:0]});
    end
    foreach (corner[j]) step(corner[j][15:8], corner[j][7:0]);
    for (int n = 0; n < 40; n++) begin
      r = $random(seed);
      step({4'h0, r[3:0]}, r[15:8]);
    end
    give_verdict();
  end
endmodule
